// ---- include/tpudc_pkg.sv ----
/*
  Package for the two-phase up/down counter channel: register map,
  field positions, reset values, timing counts and the carrier structs.
  Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
*/
package tpudc_pkg;

  // Register byte addresses (one aligned word each)
  // Status offset is word aligned, so it is kept as a word index
  localparam logic [31:0] TPUDC_IDX_STATUS = 32'hffff_f167;
  // Its byte address is four times the index, cut to the bus width
  localparam logic [11:0] TPUDC_ADDR_STATUS = 12'(TPUDC_IDX_STATUS << 2);
  localparam logic [11:0] TPUDC_ADDR_RUN = 12'h100;
  localparam logic [11:0] TPUDC_ADDR_COUNT = 12'h104;
  localparam logic [11:0] TPUDC_ADDR_CTRL = 12'h108;
  localparam logic [11:0] TPUDC_ADDR_CAPTURE = 12'h10c;

  // Run register fields
  localparam int TPUDC_RUN_BIT = 0;
  localparam int TPUDC_PRUN_BIT = 2;
  localparam int TPUDC_IDLE_BIT = 3;
  localparam int TPUDC_UDCE_BIT = 4;
  localparam int TPUDC_SCK_BIT = 5;
  localparam int TPUDC_RDE_BIT = 7;
  localparam logic [7:0] TPUDC_RUN_WMASK = 8'hbd;
  localparam logic [7:0] TPUDC_RUN_RESET = 8'h00;

  // Status register fields
  localparam int TPUDC_ST_OVF_BIT = 2;
  localparam int TPUDC_ST_UDF_BIT = 3;
  localparam int TPUDC_ST_CNT_BIT = 4;
  localparam logic [7:0] TPUDC_ST_RESET = 8'h00;

  // Control register fields (software capture, capture select, clock source)
  localparam int TPUDC_CTL_SWCAP_BIT = 0;
  localparam int TPUDC_CTL_EXTCAP_BIT = 1;
  localparam int TPUDC_CTL_CLK_LSB = 2;
  localparam logic [1:0] TPUDC_CLK_OFF = 2'h0;

  // Counter values
  localparam logic [15:0] TPUDC_CNT_INIT = 16'h7fff;
  localparam logic [15:0] TPUDC_CNT_MAX = 16'hffff;
  localparam logic [15:0] TPUDC_CNT_ZERO = 16'h0000;

  // Sample strobe: system clock divided by two
  localparam int TPUDC_SAMPLE_DIV = 2;

  // AXI responses
  localparam logic [1:0] TPUDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPUDC_RESP_SLVERR = 2'h2;

  // One counter step as reported by the phase decoder
  typedef struct packed {
    logic inc;
    logic dec;
  } tpudc_step_s;

  // Sticky status flags
  typedef struct packed {
    logic cnt;
    logic udf;
    logic ovf;
  } tpudc_flags_s;

endpackage

// ---- hw/tpudc_phase_dec.sv ----
/*
  Phase decoder: compares the held phase pair with the new sample and
  reports one increment or decrement per valid quadrature transition.
  Assumes the phase inputs are synchronous to clock and that the caller
  supplies a sample strobe and a hold signal for the stop state.
*/
`timescale 1ns/1ps
module tpudc_phase_dec (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sample_en,
  input wire logic hold,
  input wire logic phase_a,
  input wire logic phase_b,
  output tpudc_pkg::tpudc_step_s step,
  output tpudc_pkg::tpudc_step_s step_now
);

  logic [1:0] held_r; // Last accepted phase pair {a,b}
  logic [1:0] held_nxt;
  tpudc_pkg::tpudc_step_s step_r; // Registered step
  tpudc_pkg::tpudc_step_s step_nxt;

  // Gray order 00-10-11-01 counts up when phase a leads
  function automatic tpudc_pkg::tpudc_step_s decode(input logic [1:0] old_p,
                                                    input logic [1:0] new_p);
    tpudc_pkg::tpudc_step_s s;
    s = '0;
    case ({old_p, new_p})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: s.inc = 1'b1;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: s.dec = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

  // Combinational step and held state; in hold the state is frozen
  always_comb begin
    held_nxt = held_r;
    step_nxt = '0;
    if (sample_en && !hold) begin
      step_nxt = decode(held_r, {phase_a, phase_b});
      held_nxt = {phase_a, phase_b};
    end
  end

  // Wake detection looks at live pins against the frozen state
  assign step_now = decode(held_r, {phase_a, phase_b});

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      held_r <= 2'h0;
      step_r <= '0;
    end else begin
      held_r <= held_nxt;
      step_r <= step_nxt;
    end
  end

  assign step = step_r;

endmodule // tpudc_phase_dec

// ---- hw/tpudc_top.sv ----
/*
  Two-phase up/down counter channel with an AXI4-Lite register slave.
  Assumes phase inputs synchronous to clock, toggling no faster than
  fsys/16, and a stop request from the clock controller.
*/
`timescale 1ns/1ps

// Overview of operation
// - Two-phase mode counts up and down
// - Register selects capture inputs or counter
// - Every up/down count pulses the count interrupt
// - Enabling two-phase while running loads 0x7FFF
// - Up past maximum wraps to 0x0000
// - Down past zero wraps to 0xFFFF
// - Overflow bit2, underflow bit3, count bit4
// - Status read returns flags and clears
// - Up/down mode: software capture only
// - Up/down mode disables comparator
// - Sample select bit5 means fsys/2
// - Enable 0 normal timer, 1 up/down
// - Stop state holds up/down counter and inputs
// - Stopped transition raises wake interrupt
// - After warm-up, held state may count once
module tpudc_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic stop_mode,
  input wire logic [15:0] compare_value,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic count_interrupt,
  output logic wake_interrupt_a,
  output logic wake_interrupt_b,
  output logic compare_match,
  output logic capture_pulse
);

  // Bus handshake state
  typedef enum logic [2:0] {
    TPUDC_W_IDLE = 3'b001,
    TPUDC_W_HAVE = 3'b010,
    TPUDC_W_RESP = 3'b100
  } tpudc_wst_e;

  tpudc_wst_e wst_r, wst_nxt; // Write channel state
  logic aw_got_r, aw_got_nxt; // Address taken
  logic w_got_r, w_got_nxt; // Data taken
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // Channel state
  logic [7:0] run_r, run_nxt; // Run control register
  logic [7:0] ctl_r, ctl_nxt; // Capture/clock-source control
  logic [15:0] cnt_r, cnt_nxt; // 16-bit counter
  logic [15:0] cap_r, cap_nxt; // Capture register
  tpudc_pkg::tpudc_flags_s flg_r, flg_nxt; // Sticky status
  logic cint_r, cint_nxt;
  logic wka_r, wka_nxt;
  logic wkb_r, wkb_nxt;
  logic cmp_r, cmp_nxt;
  logic capp_r, capp_nxt;
  logic div_r, div_nxt; // fsys/2 sample strobe
  logic pha_r, pha_nxt; // Previous phase a for capture edge
  logic udce_d_r; // Enable bit delayed, to see its rising edge

  logic wr_fire;
  logic rd_fire;
  logic ud_mode;
  logic running;
  tpudc_pkg::tpudc_step_s step;
  tpudc_pkg::tpudc_step_s step_now;

  // Register select helper, used by both read and write paths
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
    return a[11:2] == r[11:2];
  endfunction

  assign running = run_r[tpudc_pkg::TPUDC_RUN_BIT];
  assign ud_mode = running && run_r[tpudc_pkg::TPUDC_UDCE_BIT];

  // Sampling strobe only runs when fsys/2 is selected; 0 is prohibited
  assign div_nxt = run_r[tpudc_pkg::TPUDC_SCK_BIT] ? ~div_r : 1'b0;

  tpudc_phase_dec u_dec (
    .clock(clock),
    .rst_b(rst_b),
    .sample_en(div_r && ud_mode),
    .hold(stop_mode),
    .phase_a(phase_a_input),
    .phase_b(phase_b_input),
    .step(step),
    .step_now(step_now)
  );

  // Write channel: address and data taken in either order
  always_comb begin
    wst_nxt = wst_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    wr_fire = 1'b0;
    case (wst_r)
      TPUDC_W_IDLE, TPUDC_W_HAVE: begin
        if (s_axi_awvalid && !aw_got_r) begin
          aw_got_nxt = 1'b1;
          awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_r) begin
          w_got_nxt = 1'b1;
          wdata_nxt = s_axi_wdata;
          wstrb_nxt = s_axi_wstrb;
        end
        wst_nxt = TPUDC_W_HAVE;
        if (aw_got_r && w_got_r) begin
          wr_fire = 1'b1;
          aw_got_nxt = 1'b0;
          w_got_nxt = 1'b0;
          bresp_nxt = (is_addr(awaddr_r, tpudc_pkg::TPUDC_ADDR_RUN) ||
                       is_addr(awaddr_r, tpudc_pkg::TPUDC_ADDR_CTRL)) ?
                      tpudc_pkg::TPUDC_RESP_OKAY : tpudc_pkg::TPUDC_RESP_SLVERR;
          wst_nxt = TPUDC_W_RESP;
        end
      end
      TPUDC_W_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = TPUDC_W_IDLE;
        end
      end
      default: wst_nxt = TPUDC_W_IDLE;
    endcase
  end

  // Read channel: one read in flight, answer one cycle after address
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rd_fire = 1'b0;
    if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_nxt = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = tpudc_pkg::TPUDC_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (is_addr(s_axi_araddr, tpudc_pkg::TPUDC_ADDR_STATUS)) begin
        rd_fire = 1'b1;
        rdata_nxt[7:0] = {3'h0, flg_r.cnt, flg_r.udf, flg_r.ovf, 2'h0};
      end else if (is_addr(s_axi_araddr, tpudc_pkg::TPUDC_ADDR_RUN)) begin
        rdata_nxt[7:0] = run_r;
      end else if (is_addr(s_axi_araddr, tpudc_pkg::TPUDC_ADDR_COUNT)) begin
        rdata_nxt[15:0] = cnt_r;
      end else if (is_addr(s_axi_araddr, tpudc_pkg::TPUDC_ADDR_CTRL)) begin
        rdata_nxt[7:0] = ctl_r;
      end else if (is_addr(s_axi_araddr, tpudc_pkg::TPUDC_ADDR_CAPTURE)) begin
        rdata_nxt[15:0] = cap_r;
      end else begin
        rresp_nxt = tpudc_pkg::TPUDC_RESP_SLVERR;
      end
    end
  end

  // Registers, counter, flags and event outputs
  always_comb begin
    run_nxt = run_r;
    ctl_nxt = ctl_r;
    cnt_nxt = cnt_r;
    cap_nxt = cap_r;
    flg_nxt = flg_r;
    cint_nxt = 1'b0;
    wka_nxt = 1'b0;
    wkb_nxt = 1'b0;
    cmp_nxt = 1'b0;
    capp_nxt = 1'b0;
    pha_nxt = phase_a_input;
    ctl_nxt[tpudc_pkg::TPUDC_CTL_SWCAP_BIT] = 1'b0; // Self-clearing trigger
    if (wr_fire && wstrb_r[0]) begin
      if (is_addr(awaddr_r, tpudc_pkg::TPUDC_ADDR_RUN)) begin
        run_nxt = wdata_r[7:0] & tpudc_pkg::TPUDC_RUN_WMASK;
      end
      if (is_addr(awaddr_r, tpudc_pkg::TPUDC_ADDR_CTRL)) begin
        ctl_nxt = wdata_r[7:0];
      end
    end
    // Flags clear on status read; a same-cycle event still sets them
    if (rd_fire) begin
      flg_nxt = '0;
    end
    if (!running) begin
      cnt_nxt = tpudc_pkg::TPUDC_CNT_ZERO;
    end else if (run_r[tpudc_pkg::TPUDC_UDCE_BIT] && !udce_d_r) begin
      cnt_nxt = tpudc_pkg::TPUDC_CNT_INIT;
    end else if (ud_mode) begin
      // Stop state freezes the count; step is idle in hold
      if (step.inc) begin
        cnt_nxt = cnt_r + 16'h0001;
        flg_nxt.cnt = 1'b1;
        cint_nxt = 1'b1;
        if (cnt_r == tpudc_pkg::TPUDC_CNT_MAX) begin
          flg_nxt.ovf = 1'b1;
        end
      end else if (step.dec) begin
        cnt_nxt = cnt_r - 16'h0001;
        flg_nxt.cnt = 1'b1;
        cint_nxt = 1'b1;
        if (cnt_r == tpudc_pkg::TPUDC_CNT_ZERO) begin
          flg_nxt.udf = 1'b1;
        end
      end
    end else if (run_r[tpudc_pkg::TPUDC_PRUN_BIT]) begin
      // Normal timer: plain up-count when the prescaler feed runs
      cnt_nxt = cnt_r + 16'h0001;
      cmp_nxt = (cnt_r == compare_value);
    end
    // Stopped: a valid transition on the pins requests wake-up
    if (stop_mode && ud_mode) begin
      wka_nxt = step_now.inc;
      wkb_nxt = step_now.dec;
    end
    // Capture: external edge only outside up/down mode
    if (ctl_r[tpudc_pkg::TPUDC_CTL_SWCAP_BIT] ||
        (!ud_mode && ctl_r[tpudc_pkg::TPUDC_CTL_EXTCAP_BIT] &&
         phase_a_input && !pha_r)) begin
      cap_nxt = cnt_r;
      capp_nxt = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wst_r <= TPUDC_W_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
      run_r <= tpudc_pkg::TPUDC_RUN_RESET;
      ctl_r <= 8'h00;
      cnt_r <= 16'h0000;
      cap_r <= 16'h0000;
      flg_r <= '0;
      cint_r <= 1'b0;
      wka_r <= 1'b0;
      wkb_r <= 1'b0;
      cmp_r <= 1'b0;
      capp_r <= 1'b0;
      div_r <= 1'b0;
      pha_r <= 1'b0;
      udce_d_r <= 1'b0;
    end else begin
      wst_r <= wst_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      run_r <= run_nxt;
      ctl_r <= ctl_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      flg_r <= flg_nxt;
      cint_r <= cint_nxt;
      wka_r <= wka_nxt;
      wkb_r <= wkb_nxt;
      cmp_r <= cmp_nxt;
      capp_r <= capp_nxt;
      div_r <= div_nxt;
      pha_r <= pha_nxt;
      // Only the enable bit itself reloads; a run restart keeps the cleared count
      udce_d_r <= run_r[tpudc_pkg::TPUDC_UDCE_BIT];
    end
  end

  // Bus outputs all come from flip-flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= (wst_nxt != TPUDC_W_RESP) && !aw_got_nxt;
      s_axi_wready <= (wst_nxt != TPUDC_W_RESP) && !w_got_nxt;
      s_axi_arready <= !rvalid_nxt;
    end
  end

  assign s_axi_bvalid = wst_r[2]; // One-hot response state bit, straight from its flop
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign count_interrupt = cint_r;
  assign wake_interrupt_a = wka_r;
  assign wake_interrupt_b = wkb_r;
  assign compare_match = cmp_r;
  assign capture_pulse = capp_r;

endmodule // tpudc_top

// ---- bench/tpudc_enc_model.sv ----
/* Two-phase pulse source standing in for an encoder.
   Assumes the bench pulses req with dir for one cycle and waits on busy. */
`timescale 1ns/1ps
module tpudc_enc_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req,
  input wire logic dir,
  output logic phase_a,
  output logic phase_b,
  output logic busy
);
  logic [1:0] pos_r; // Gray position 0..3
  logic [3:0] gap_r; // Hold time left before next move
  // One gray step per request, then a long hold: slower than fsys/16
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pos_r <= 2'h0;
      gap_r <= 4'h0;
    end else if (req && gap_r == 4'h0) begin
      pos_r <= dir ? pos_r + 2'h1 : pos_r - 2'h1;
      gap_r <= 4'hf;
    end else if (gap_r != 4'h0) begin
      gap_r <= gap_r - 4'h1;
    end
  end
  // Gray code keeps the other phase steady around each edge
  assign phase_a = pos_r[0] ^ pos_r[1];
  assign phase_b = pos_r[1];
  assign busy = gap_r != 4'h0;
endmodule // tpudc_enc_model

// ---- bench/tpudc_top_asserts.sv ----
/* Port checker for the up/down counter channel.
   Assumes it is bound to tpudc_top and sees only its ports. */
`timescale 1ns/1ps
module tpudc_top_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic stop_mode,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic count_interrupt,
  input wire logic wake_interrupt_a,
  input wire logic wake_interrupt_b
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [1:0] ph_r; // Phase pair one cycle ago
  logic [3:0] age_r; // Cycles since a pin move or stop, saturating
  logic [3:0] age_nxt;
  // Stop also restarts the age, since the held state may count on exit
  always_comb begin
    age_nxt = age_r;
    if ({phase_a_input, phase_b_input} != ph_r || stop_mode) begin
      age_nxt = 4'h0;
    end else if (age_r != 4'hf) begin
      age_nxt = age_r + 4'h1;
    end
  end
  // Register the age tracker
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ph_r <= 2'h0;
      age_r <= 4'hf;
    end else begin
      ph_r <= {phase_a_input, phase_b_input};
      age_r <= age_nxt;
    end
  end
  count_has_cause_a: assert property (count_interrupt |-> age_r <= 4'h7)
    else $error("count pulse without a recent phase move");
  count_one_cycle_a: assert property (count_interrupt |=> !count_interrupt)
    else $error("count pulse longer than one cycle");
  stop_holds_a: assert property (stop_mode [*4] |-> !count_interrupt)
    else $error("counter moved while stopped");
  wake_in_stop_a: assert property (wake_interrupt_a |-> stop_mode || $past(stop_mode))
    else $error("wake a outside stop");
  wake_exclusive_a: assert property (!(wake_interrupt_a && wake_interrupt_b))
    else $error("both wake lines high");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  cover property (count_interrupt);
  cover property (wake_interrupt_a);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // tpudc_top_asserts
bind tpudc_top tpudc_top_asserts tpudc_top_asserts_i (.clock, .rst_b, .phase_a_input,
  .phase_b_input, .stop_mode, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .count_interrupt, .wake_interrupt_a, .wake_interrupt_b);

// ---- bench/tb_tpudc_top.sv ----
/* Self-checking bench for tpudc_top over AXI4-Lite with an encoder model.
   Assumes the package constants and the hand-over timing of the design. */
`timescale 1ns/1ps
module tb_tpudc_top;
  logic clock, rst_b, stop_mode, req, dir, busy;
  logic phase_a_input, phase_b_input;
  logic [15:0] compare_value;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic count_interrupt, wake_interrupt_a, wake_interrupt_b, compare_match, capture_pulse;
  int errors, tests_run, n_ci, n_wk, n_wb, n_cm, n_cp; // Check and error tallies, then counters of outputs seen
  localparam logic [1:0] OK = tpudc_pkg::TPUDC_RESP_OKAY;
  localparam logic [1:0] ERR = tpudc_pkg::TPUDC_RESP_SLVERR;
  localparam logic [11:0] RUN = tpudc_pkg::TPUDC_ADDR_RUN;
  localparam logic [11:0] CNT = tpudc_pkg::TPUDC_ADDR_COUNT;
  localparam logic [11:0] CTL = tpudc_pkg::TPUDC_ADDR_CTRL;
  localparam logic [11:0] STA = tpudc_pkg::TPUDC_ADDR_STATUS;

  tpudc_top tpudc_top_i (.clock, .rst_b, .phase_a_input, .phase_b_input, .stop_mode,
    .compare_value, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_interrupt, .wake_interrupt_a,
    .wake_interrupt_b, .compare_match, .capture_pulse);
  tpudc_enc_model tpudc_enc_model_i (.clock, .rst_b, .req, .dir,
    .phase_a(phase_a_input), .phase_b(phase_b_input), .busy);

  // 100 MHz clock
  always #5 clock = ~clock;
  // Tally the pulse outputs so scenarios can check how many arrived
  always @(posedge clock) begin
    n_ci += count_interrupt;
    n_wk += wake_interrupt_a;
    n_wb += wake_interrupt_b;
    n_cm += compare_match;
    n_cp += capture_pulse;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // A used-up bound counts as a mismatch and ends the run
  task automatic tmo(input int n);
    if (n >= 99) begin
      errors++;
      test_done();
    end
  endtask
  // AXI write: offer address and data together, release each when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit ad, wd;
    n = 0;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd) && n < 99) begin
      @(posedge clock);
      n++;
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clock);
      n++;
    end while (!s_axi_bvalid && n < 99);
    tmo(n);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // AXI read: result left in rdat
  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (!s_axi_arready && n < 99);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (!s_axi_rvalid && n < 99);
    tmo(n);
    rdat = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a, OK);
    chk("rdata", e, rdat);
  endtask
  // One gray step from the encoder, waiting out its hold time
  task automatic step(input logic up);
    int n;
    n = 0;
    @(posedge clock);
    req <= 1'b1;
    dir <= up;
    @(posedge clock);
    req <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (busy && n < 99);
    tmo(n);
  endtask

  initial begin
    clock = 0; rst_b = 0; stop_mode = 0; req = 0; dir = 0; compare_value = 16'h8000;
    s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hf;
    s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0;
    s_axi_rready = 0; errors = 0; tests_run = 0; n_ci = 0; n_wk = 0; n_cm = 0; n_cp = 0; n_wb = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rc(RUN, 32'h0);
    rc(STA, 32'h0);
    rd(12'h1f0, ERR);
    wr(CTL, 32'h2, OK);
    wr(RUN, 32'h31, OK);
    rc(CNT, 32'h7fff);
    step(1);
    rc(CNT, 32'h8000);
    rc(STA, 32'h10);
    rc(STA, 32'h0);
    step(0);
    step(0);
    rc(CNT, 32'h7ffe);
    chk("count pulses", 32'd3, n_ci);
    chk("compare", 32'd0, n_cm);
    chk("pin capture", 32'd0, n_cp);
    wr(CTL, 32'h1, OK);
    repeat (4) @(posedge clock);
    chk("sw capture", 32'd1, n_cp);
    rc(tpudc_pkg::TPUDC_ADDR_CAPTURE, 32'h7ffe);
    wr(CNT, 32'h0, ERR);
    wr(RUN, 32'h30, OK);
    wr(RUN, 32'h31, OK);
    rc(CNT, 32'h0);
    step(0);
    rc(CNT, 32'hffff);
    rc(STA, 32'h18);
    step(1);
    rc(CNT, 32'h0);
    rc(STA, 32'h14);
    wr(RUN, 32'h11, OK);
    step(1);
    rc(CNT, 32'h0);
    step(0); // Pins back to the held pair, so re-enabling counts nothing
    wr(RUN, 32'h21, OK);
    wr(RUN, 32'h31, OK);
    rc(CNT, 32'h7fff);
    stop_mode <= 1'b1;
    step(1);
    rc(CNT, 32'h7fff);
    chk("wake", 32'd1, 32'(n_wk > 0));
    chk("wake b", 32'd0, n_wb);
    stop_mode <= 1'b0;
    repeat (8) @(posedge clock);
    rc(CNT, 32'h8000);
    wr(RUN, 32'h04, OK);
    compare_value <= 16'h0020;
    wr(RUN, 32'h05, OK);
    begin : cmp_wait
      int n;
      n = 0;
      while (n_cm == 0 && n < 99) begin
        @(posedge clock);
        n++;
      end
      tmo(n);
    end
    chk("match", 32'd1, n_cm);
    test_done();
  end
endmodule // tb_tpudc_top
